/* File: hw/gdio_pkg.sv */
// constants shared by the general digital i/o port
package gdio_pkg;

  // port geometry
  localparam int unsigned PIN_COUNT = 8;
  localparam int unsigned ADDR_WIDTH = 2;
  localparam int unsigned BITNUM_WIDTH = 3;

  // register indices inside the port's i/o window
  localparam logic [1:0] INPUT_PINS_IDX = 2'h0;
  localparam logic [1:0] DIRECTION_IDX = 2'h1;
  localparam logic [1:0] OUTPUT_VALUE_IDX = 2'h2;

  // values after reset and of unmapped reads
  localparam logic [7:0] DIRECTION_RESET = 8'h00;
  localparam logic [7:0] OUTPUT_VALUE_RESET = 8'h00;
  localparam logic [7:0] INPUT_PINS_RESET = 8'h00;
  localparam logic [7:0] RDATA_RESET = 8'h00;
  localparam logic [7:0] UNMAPPED_RDATA = 8'h00;
  localparam logic [7:0] PAD_RESET = 8'h00;

  // synchroniser timing, in half periods of the clock
  localparam int unsigned SYNC_MIN_HALF_PERIODS = 1;
  localparam int unsigned SYNC_MAX_HALF_PERIODS = 3;
  // software written value to input pins register, in clock cycles
  localparam int unsigned WRITE_TO_PINS_CYCLES = 1;

  // synchroniser stages
  typedef enum logic [1:0] {
    GDIO_STAGE_LATCH = 2'h1,
    GDIO_STAGE_PINS = 2'h2
  } gdio_stage_t;

endpackage : gdio_pkg

/* File: hw/gdio_port.sv */
// one 8-bit general digital i/o port with pad control and synchroniser
`timescale 1ns/10ps

module gdio_port (
  // clock and reset
  input wire logic clock,
  input wire logic rstn,
  // i/o register port
  input wire logic io_sel,
  input wire logic [1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic io_bit_wr,
  input wire logic [2:0] io_bit_num,
  input wire logic io_bit_val,
  output logic [7:0] io_rdata,
  // shared control from the mcu control register and sleep controller
  input wire logic global_pullup_disable,
  input wire logic sleep_clamp,
  input wire logic [7:0] clamp_override,
  // alternate function overrides, one bit per pin
  input wire logic [7:0] alt_pullup_oe,
  input wire logic [7:0] alt_pullup_ov,
  input wire logic [7:0] alt_dir_oe,
  input wire logic [7:0] alt_dir_ov,
  input wire logic [7:0] alt_value_oe,
  input wire logic [7:0] alt_value_ov,
  input wire logic [7:0] alt_toggle,
  input wire logic [7:0] alt_din_oe,
  input wire logic [7:0] alt_din_ov,
  // pads
  input wire logic [7:0] pad_in,
  output logic [7:0] pad_out,
  output logic [7:0] pad_oe,
  output logic [7:0] pad_pullup
);

  // one-hot mask of a pin number, used for every bit operation
  function automatic logic [7:0] pin_mask(input logic [2:0] num);
    logic [7:0] m;
    m = 8'h00;
    m[num] = 1'b1;
    return m;
  endfunction : pin_mask

  // set or clear the masked bits, leave all others
  function automatic logic [7:0] bit_apply(
    input logic [7:0] cur,
    input logic [7:0] m,
    input logic val
  );
    logic [7:0] r;
    r = val ? (cur | m) : (cur & ~m);
    return r;
  endfunction : bit_apply

  // register state
  logic [7:0] direction_register_q;
  logic [7:0] direction_register_d;
  logic [7:0] output_value_register_q;
  logic [7:0] output_value_register_d;
  logic [7:0] io_rdata_q;
  logic [7:0] io_rdata_d;

  // pad state
  logic [7:0] pad_out_q;
  logic [7:0] pad_out_d;
  logic [7:0] pad_oe_q;
  logic [7:0] pad_oe_d;
  logic [7:0] pad_pullup_q;
  logic [7:0] pad_pullup_d;

  // synchroniser state
  logic [7:0] sync_latch_q;
  logic [7:0] sync_latch_d;
  logic [7:0] input_pins_register_q;
  logic [7:0] input_pins_register_d;

  // per-pin digital input enable and gated pad level
  logic [7:0] din_enable;
  logic [7:0] din_gated;

  // decoded strobes
  logic wr_en;
  logic bit_en;
  logic rd_en;
  logic [7:0] bit_mask;

  assign wr_en = io_sel & io_wr;
  assign bit_en = io_sel & io_bit_wr;
  assign rd_en = io_sel & io_rd;
  assign bit_mask = pin_mask(io_bit_num);

  // register write path
  always_comb begin
    direction_register_d = direction_register_q;
    output_value_register_d = output_value_register_q;
    if (wr_en) begin
      unique case (io_addr)
        gdio_pkg::DIRECTION_IDX: begin
          direction_register_d = io_wdata;
        end
        gdio_pkg::OUTPUT_VALUE_IDX: begin
          output_value_register_d = io_wdata;
        end
        gdio_pkg::INPUT_PINS_IDX: begin
          // ones toggle, zeros leave the bit alone
          output_value_register_d = output_value_register_q ^ io_wdata;
        end
        default: begin
          // unmapped location, write ignored
        end
      endcase
    end
    // bit operations act on the result of a same-cycle byte write
    if (bit_en) begin
      unique case (io_addr)
        gdio_pkg::DIRECTION_IDX: begin
          direction_register_d = bit_apply(direction_register_d,
            bit_mask, io_bit_val);
        end
        gdio_pkg::OUTPUT_VALUE_IDX: begin
          output_value_register_d = bit_apply(output_value_register_d,
            bit_mask, io_bit_val);
        end
        gdio_pkg::INPUT_PINS_IDX: begin
          if (io_bit_val) begin
            output_value_register_d = output_value_register_d ^ bit_mask;
          end
        end
        default: begin
          // unmapped location, bit operation ignored
        end
      endcase
    end
    // alternate toggle override applies per pin only
    output_value_register_d = output_value_register_d ^ alt_toggle;
  end

  // pad control, computed from next register values so pads move with them
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++) begin : g_pin
      // driver enable follows direction unless overridden
      assign pad_oe_d[gi] = alt_dir_oe[gi] ? alt_dir_ov[gi]
                          : direction_register_d[gi];
      // driven level follows the value bit unless overridden
      assign pad_out_d[gi] = alt_value_oe[gi] ? alt_value_ov[gi]
                           : output_value_register_d[gi];
      // pull-up for input with value one and no global disable, unless overridden
      assign pad_pullup_d[gi] = alt_pullup_oe[gi] ? alt_pullup_ov[gi]
                              : (~direction_register_d[gi]
                                 & output_value_register_d[gi]
                                 & ~global_pullup_disable);
      // deep sleep clamps the input low unless this pin opts out
      assign din_enable[gi] = alt_din_oe[gi] ? alt_din_ov[gi]
                            : (~sleep_clamp | clamp_override[gi]);
      assign din_gated[gi] = pad_in[gi] & din_enable[gi];
    end
  endgenerate

  // software visible register flip-flops
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      direction_register_q <= gdio_pkg::DIRECTION_RESET;
      output_value_register_q <= gdio_pkg::OUTPUT_VALUE_RESET;
    end else begin
      direction_register_q <= direction_register_d;
      output_value_register_q <= output_value_register_d;
    end
  end

  // pad control flip-flops
  // kept apart from the registers: their reset must act with no clock
  // running, and the pad outputs must never glitch through logic
  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      // clearing enables without a clock keeps pins undriven
      pad_oe_q <= gdio_pkg::PAD_RESET;
      pad_out_q <= gdio_pkg::PAD_RESET;
      pad_pullup_q <= gdio_pkg::PAD_RESET;
    end else begin
      pad_oe_q <= pad_oe_d;
      pad_out_q <= pad_out_d;
      pad_pullup_q <= pad_pullup_d;
    end
  end

  // synchroniser front stage
  // a falling-edge stage stands in for the high-phase transparent latch:
  // it holds what the pad showed at the end of the high phase
  always_comb begin
    sync_latch_d = din_gated;
  end

  always_ff @(negedge clock or negedge rstn) begin
    if (!rstn) begin
      sync_latch_q <= gdio_pkg::INPUT_PINS_RESET;
    end else begin
      sync_latch_q <= sync_latch_d;
    end
  end

  // synchroniser back stage: rising edge after the latch closes
  always_comb begin
    input_pins_register_d = sync_latch_q;
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      input_pins_register_q <= gdio_pkg::INPUT_PINS_RESET;
    end else begin
      // driven pins loop back through the pad, one cycle after the write
      input_pins_register_q <= input_pins_register_d;
    end
  end

  // read path, registered so the bus sees data one cycle after the strobe
  always_comb begin
    io_rdata_d = io_rdata_q;
    if (rd_en) begin
      unique case (io_addr)
        gdio_pkg::INPUT_PINS_IDX: begin
          io_rdata_d = input_pins_register_q;
        end
        gdio_pkg::DIRECTION_IDX: begin
          io_rdata_d = direction_register_q;
        end
        gdio_pkg::OUTPUT_VALUE_IDX: begin
          io_rdata_d = output_value_register_q;
        end
        default: begin
          io_rdata_d = gdio_pkg::UNMAPPED_RDATA;
        end
      endcase
    end
  end

  always_ff @(posedge clock or negedge rstn) begin
    if (!rstn) begin
      io_rdata_q <= gdio_pkg::RDATA_RESET;
    end else begin
      io_rdata_q <= io_rdata_d;
    end
  end

  // outputs straight from flip-flops
  assign io_rdata = io_rdata_q;
  assign pad_out = pad_out_q;
  assign pad_oe = pad_oe_q;
  assign pad_pullup = pad_pullup_q;

endmodule : gdio_port

/* File: bench/gdio_port_assertions.sv */
// concurrent checks on the general digital i/o port pins and registers
`timescale 1ns/10ps
module gdio_port_assertions (
  // clock, reset and register port
  input wire logic clock,
  input wire logic rstn,
  input wire logic io_sel,
  input wire logic [1:0] io_addr,
  input wire logic io_wr,
  input wire logic io_rd,
  input wire logic [7:0] io_wdata,
  input wire logic io_bit_wr,
  input wire logic [2:0] io_bit_num,
  input wire logic io_bit_val,
  input wire logic [7:0] io_rdata,
  // control and pads
  input wire logic global_pullup_disable,
  input wire logic sleep_clamp,
  input wire logic [7:0] alt_pullup_oe,
  input wire logic [7:0] pad_in,
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup
);
  default clocking @(posedge clock); endclocking
  default disable iff (!rstn);
  logic bw;
  logic bo;
  logic rd;
  assign bw = io_sel && io_wr && !io_bit_wr;
  assign bo = io_sel && io_bit_wr && !io_wr;
  assign rd = io_sel && io_rd;
  chk_reset_tristate: assert property (disable iff (1'b0)
    !rstn |-> pad_oe == 8'h00) else $error("pins driven in reset");
  chk_dir_write: assert property (bw && io_addr == 2'h1 |=>
    pad_oe == $past(io_wdata)) else $error("direction not applied");
  chk_pins_toggle: assert property (bw && io_addr == 2'h0 |=>
    pad_out == ($past(pad_out) ^ $past(io_wdata))) else $error("toggle");
  chk_pullup_table: assert property (pad_pullup ==
    (~pad_oe & pad_out & {8{!$past(global_pullup_disable)}}
    & ~$past(alt_pullup_oe)) | (pad_pullup & $past(alt_pullup_oe)))
    else $error("pull-up mismatch");
  chk_bit_only: assert property (bo && io_addr == 2'h1 |=>
    ((pad_oe ^ $past(pad_oe)) & ~(8'h01 << $past(io_bit_num))) == 8'h00
    && pad_oe[$past(io_bit_num)] == $past(io_bit_val))
    else $error("bit op disturbed other pins");
  chk_read_dir: assert property (rd && io_addr == 2'h1 |=>
    io_rdata == $past(pad_oe)) else $error("direction read");
  chk_unmapped_read: assert property (rd && io_addr == 2'h3 |=>
    io_rdata == 8'h00) else $error("unmapped read");
  chk_pins_sync: assert property (rd && io_addr == 2'h0 &&
    !sleep_clamp && $stable(pad_in) && $past(rstn) |=>
    io_rdata == $past(pad_in)) else $error("input pins value");
endmodule : gdio_port_assertions

/* File: bench/gdio_pad_model.sv */
// external pads: port drivers, pull-ups, a source and floating pins
`timescale 1ns/10ps
module gdio_pad_model (
  // clock for the drifting level
  input wire logic clock,
  // port and external source
  input wire logic [7:0] pad_out,
  input wire logic [7:0] pad_oe,
  input wire logic [7:0] pad_pullup,
  input wire logic [7:0] ext_en,
  input wire logic [7:0] ext_val,
  output logic [7:0] pad_in
);
  logic [7:0] float_q = 8'h5A;
  logic [7:0] free;
  // undriven pins without a pull-up drift so a stale level never passes for a real one
  always @(posedge clock) float_q <= ~float_q;
  always_comb begin
    free = ~pad_oe & ~ext_en;
    pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val);
    pad_in = pad_in | (free & (pad_pullup | float_q));
  end
endmodule : gdio_pad_model

/* File: bench/gdio_port_test.sv */
// self-checking bench for the general digital i/o port
`timescale 1ns/10ps
module gdio_port_test;
  logic clock, rstn, io_sel, io_wr, io_rd, io_bit_wr, io_bit_val;
  logic global_pullup_disable, sleep_clamp;
  logic [1:0] io_addr;
  logic [2:0] io_bit_num;
  logic [7:0] io_wdata, io_rdata, clamp_override, alt_q, ext_en, ext_val;
  logic [7:0] pad_in, pad_out, pad_oe, pad_pullup;
  int fail_count, total_checks;
  gdio_port u_dut (.*, .alt_pullup_oe(alt_q), .alt_pullup_ov(alt_q),
    .alt_dir_oe(alt_q), .alt_dir_ov(alt_q), .alt_value_oe(alt_q),
    .alt_value_ov(alt_q), .alt_toggle(alt_q), .alt_din_oe(alt_q),
    .alt_din_ov(alt_q));
  gdio_pad_model u_pads (.*);
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic io_rw(input logic [1:0] a, input logic [7:0] d,
    input logic w);
    @(posedge clock);
    io_addr <= a;
    io_wdata <= d;
    io_wr <= w;
    io_rd <= !w;
    @(posedge clock);
    io_wr <= 1'b0;
    io_rd <= 1'b0;
    #1;
  endtask : io_rw
  task automatic rd(input logic [1:0] a, input logic [7:0] exp);
    io_rw(a, 8'h00, 1'b0);
    check(io_rdata, exp);
  endtask : rd
  task automatic bitop(input logic [1:0] a, input logic [2:0] n,
    input logic v);
    @(posedge clock);
    io_addr <= a;
    io_bit_num <= n;
    io_bit_val <= v;
    io_bit_wr <= 1'b1;
    @(posedge clock);
    io_bit_wr <= 1'b0;
    #1;
  endtask : bitop
  task automatic stop_test;
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic t_config;
    io_rw(2'h2, 8'hC3, 1'b1);
    check(pad_pullup, 8'hC3);
    io_rw(2'h1, 8'h0F, 1'b1);
    check(pad_oe, 8'h0F);
    check(pad_out, 8'hC3);
    check(pad_pullup, 8'hC0);
    rd(2'h0, 8'hC3);
    @(posedge clock);
    global_pullup_disable <= 1'b1;
    @(posedge clock);
    #1 check(pad_pullup, 8'h00);
    @(posedge clock);
    global_pullup_disable <= 1'b0;
  endtask : t_config
  task automatic t_toggle;
    io_rw(2'h0, 8'h81, 1'b1);
    check(pad_out, 8'h42);
    bitop(2'h0, 3'h2, 1'b0);
    check(pad_out, 8'h42);
    bitop(2'h0, 3'h2, 1'b1);
    rd(2'h2, 8'h46);
  endtask : t_toggle
  task automatic t_bits;
    bitop(2'h1, 3'h6, 1'b1);
    check(pad_oe, 8'h4F);
    bitop(2'h1, 3'h0, 1'b0);
    io_rw(2'h3, 8'hFF, 1'b1);
    rd(2'h3, 8'h00);
    rd(2'h1, 8'h4E);
  endtask : t_bits
  task automatic t_alt;
    @(posedge clock);
    alt_q <= 8'h01;
    @(posedge clock);
    alt_q <= 8'h00;
    #1 check(pad_oe, 8'h4F);
    check(pad_out, 8'h47);
    check(pad_pullup, 8'h01);
    rd(2'h2, 8'h47);
    rd(2'h1, 8'h4E);
  endtask : t_alt
  task automatic t_input;
    @(posedge clock);
    ext_val <= 8'h30;
    io_rw(2'h0, 8'h00, 1'b0);
    check(io_rdata & 8'h70, 8'h70);
    @(posedge clock);
    sleep_clamp <= 1'b1;
    clamp_override <= 8'h20;
    repeat (2) @(posedge clock);
    io_rw(2'h0, 8'h00, 1'b0);
    check(io_rdata & 8'h70, 8'h20);
    @(posedge clock);
    sleep_clamp <= 1'b0;
  endtask : t_input
  task automatic t_reset;
    io_rw(2'h1, 8'hFF, 1'b1);
    @(posedge clock);
    rstn <= 1'b0;
    #1 check(pad_oe, 8'h00);
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    rd(2'h2, 8'h00);
    rd(2'h1, 8'h00);
  endtask : t_reset
  initial begin
    clock = 1'b0;
    forever #10 clock = ~clock;
  end
  initial begin
    #50000;
    fail_count++;
    stop_test();
  end
  initial begin
    {rstn, io_wr, io_rd, io_bit_wr, io_bit_val, sleep_clamp} = '0;
    {io_addr, io_bit_num, io_wdata, clamp_override, alt_q, ext_val} = '0;
    {global_pullup_disable, io_sel, ext_en} = {2'b01, 8'h30};
    repeat (8) @(posedge clock);
    rstn <= 1'b1;
    #1 check(pad_pullup, 8'h00);
    t_config();
    t_toggle();
    t_bits();
    t_alt();
    t_input();
    t_reset();
    stop_test();
  end
endmodule : gdio_port_test
bind gdio_port gdio_port_assertions u_chk (.*);
